/* File: core/cqt_top.v */
// Summary of operation
// - A control bit turns temperature qualification off, bypassing zone limits.
// - Lower thermistor voltage means hotter; thresholds descend cold to hot.
// - A new charge cycle starts only inside the cold-to-hot window.
// - Leaving the window while charging forces zero current until return.
// - Warm zone voltage is min(setting, 4.1V) if select 0, else setting.
// - Warm zone current is 0%, 20%, 50% or 100% per two-bit select.
// - Cool zone current is 50% or 20% when enabled, zero when disabled.
// - Cool zone voltage is setting if select 0, else min(setting, 4.1V).
// - Cool and warm boundaries each chosen by a two-bit field.
// - Boost outside its window suspends, source status 000, fault cold/hot.
// - Boost back in window resumes and clears thermistor fault to 000.
// - Timer expiry stops charging, fault code 11, interrupt pulse.
// - Limit is 2 hours below low-battery threshold, 7 or 16 hours above per select bit.
// - Timer runs half rate in input limits, cool zone, thermal limit.
// - Timer holds while a fault suspends charging, resumes afterwards.
// - Timer clears on cycle restart or enable pin or config toggle.
// - Three-bit minimum system voltage, default 3.5V; flag while regulating.
// - Battery below minimum: system target is minimum plus 180mV.
// - After termination or disabled above minimum: battery plus 50mV.
// - Input current and voltage limit flags follow the active limits while charging.
// - Each interrupt is a 256us low pulse on the interrupt pin.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "cqt_map.vh"
module cqt_top #(
   parameter [63:0] CYCLES_PER_HOUR = `CQT_CYCLES_PER_HOUR,
   parameter IRQ_CYCLES = `CQT_IRQ_CYCLES,
   parameter DEBOUNCE = `CQT_DEBOUNCE_CYCLES
) (
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // AXI4-Lite write address and data
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Thermistor comparators, high when sense voltage is above threshold; cold_cmp and boost_cold_cmp high when below
   input wire [3:0] cool_cmp,
   input wire [3:0] warm_cmp,
   input wire cold_cmp,
   input wire hot_cmp,
   input wire boost_cold_cmp,
   input wire boost_hot_cmp,
   // Analog status
   input wire charge_enable_n,
   input wire bat_above_low,
   input wire bat_above_sysmin,
   input wire bat_full,
   input wire recharge_req,
   input wire terminated,
   input wire input_current_limit,
   input wire input_voltage_limit,
   input wire thermal_limit,
   input wire other_fault,
   input wire [12:0] battery_mv,
   // Charger outputs
   output reg charging,
   output reg boost_active,
   output reg [7:0] charge_current,
   output reg [12:0] charge_voltage,
   output reg [12:0] system_target,
   output reg host_irq_n
);
   reg [31:0] ctrl;
   reg [31:0] chg;
   reg [1:0] charge_fault_code;
   reg [2:0] thermistor_fault;
   reg [2:0] input_source_status;
   reg [2:0] zone;
   reg [43:0] timer;
   reg half_tick;
   reg [1:0] en_sync;
   reg en_last;
   reg cfg_last;
   reg in_window;
   reg expire_evt;
   reg aw_hold;
   reg w_hold;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg system_regulation_flag;
   reg input_current_limit_flag;
   reg input_voltage_limit_flag;
   reg [2:0] next_zone;
   reg [7:0] next_current;
   reg [12:0] next_voltage;
   reg [12:0] next_target;
   reg [43:0] limit;
   reg [31:0] rd_word;
   wire [13:0] cmp_clean;
   wire irq_pin;
   wire irq_trigger;
   wire temp_en = ctrl[`CQT_CTRL_TEMP_EN];
   wire timer_en = ctrl[`CQT_CTRL_TIMER_EN];
   wire long_limit_select = ctrl[`CQT_CTRL_LONG_SEL];
   wire half_rate_enable = ctrl[`CQT_CTRL_HALF_EN];
   wire charge_config_bit = ctrl[`CQT_CTRL_CHG_CFG];
   wire warm_voltage_select = ctrl[`CQT_CTRL_WARM_V];
   wire [1:0] warm_current_select = ctrl[`CQT_CTRL_WARM_I_LO+1:
      `CQT_CTRL_WARM_I_LO];
   wire cool_current_select = ctrl[`CQT_CTRL_COOL_I];
   wire cool_current_enable = ctrl[`CQT_CTRL_COOL_EN];
   wire cool_voltage_select = ctrl[`CQT_CTRL_COOL_V];
   wire [1:0] cool_threshold_select = ctrl[`CQT_CTRL_COOL_T_LO+1:
      `CQT_CTRL_COOL_T_LO];
   wire [1:0] warm_threshold_select = ctrl[`CQT_CTRL_WARM_T_LO+1:
      `CQT_CTRL_WARM_T_LO];
   wire [2:0] min_system_voltage = ctrl[`CQT_CTRL_SYSMIN_LO+2:
      `CQT_CTRL_SYSMIN_LO];
   wire boost_req = ctrl[`CQT_CTRL_BOOST];
   wire [7:0] fast_current = chg[7:0];
   wire [12:0] charge_voltage_setting = chg[28:16];
   wire cool_cmp_sel = cmp_clean[cool_threshold_select];
   wire warm_cmp_sel = cmp_clean[4 + warm_threshold_select];
   wire cold_ok = cmp_clean[8];
   wire hot_ok = cmp_clean[9];
   wire boost_ok = cmp_clean[10] & cmp_clean[11];
   wire charge_allowed = charge_config_bit & ~en_sync[1];
   wire toggle = (en_sync[1] != en_last) | (charge_config_bit != cfg_last);
   wire [12:0] sysmin_mv = `CQT_SYSMIN_BASE_MV +
      {10'h000, min_system_voltage} * `CQT_SYSMIN_STEP_MV;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;

   // Fraction of fast-charge current in steps of tenths
   function [7:0] scale;
      input [7:0] base;
      input [3:0] tenths;
      reg [11:0] prod;
      reg [11:0] quot;
      begin
         prod = base * tenths;
         quot = prod / 12'd10;
         scale = quot[7:0];
      end
   endfunction

   function [12:0] min_mv;
      input [12:0] a;
      input [12:0] b;
      begin
         min_mv = (a < b) ? a : b;
      end
   endfunction

   cqt_debounce #(
      .WIDTH(14),
      .COUNT(DEBOUNCE)
   ) u_debounce (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .raw({2'b00, boost_hot_cmp, boost_cold_cmp, hot_cmp, cold_cmp,
         warm_cmp, cool_cmp}),
      .clean(cmp_clean)
   );

   cqt_irq_pulse #(
      .CYCLES(IRQ_CYCLES)
   ) u_irq (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .trigger(irq_trigger),
      .irq_n(irq_pin)
   );

   assign irq_trigger = expire_evt;

   // Zone decode: comparator high means sense voltage above threshold, except cold_cmp high means below
   always @* begin
      if (!cold_ok) begin
         next_zone = `CQT_ZONE_COLD;
      end else if (cool_cmp_sel) begin
         next_zone = `CQT_ZONE_COOL;
      end else if (!hot_ok) begin
         next_zone = `CQT_ZONE_HOT;
      end else if (!warm_cmp_sel) begin
         next_zone = `CQT_ZONE_WARM;
      end else begin
         next_zone = `CQT_ZONE_NORMAL;
      end
   end

   // Current and voltage caps by zone
   always @* begin
      next_current = fast_current;
      next_voltage = charge_voltage_setting;
      if (temp_en) begin
         case (zone)
            `CQT_ZONE_COOL: begin
               if (!cool_current_enable) begin
                  next_current = 8'h00;
               end else begin
                  next_current = scale(fast_current,
                     cool_current_select ? 4'h2 : 4'h5);
               end
               if (cool_voltage_select) begin
                  next_voltage = min_mv(charge_voltage_setting,
                     `CQT_WARM_MV);
               end
            end
            `CQT_ZONE_WARM: begin
               case (warm_current_select)
                  2'h0: next_current = 8'h00;
                  2'h1: next_current = scale(fast_current, 4'h2);
                  2'h2: next_current = scale(fast_current, 4'h5);
                  default: next_current = fast_current;
               endcase
               if (!warm_voltage_select) begin
                  next_voltage = min_mv(charge_voltage_setting,
                     `CQT_WARM_MV);
               end
            end
            `CQT_ZONE_NORMAL: next_current = fast_current;
            default: next_current = 8'h00;
         endcase
      end
      if (!charging) begin
         next_current = 8'h00;
      end
   end

   // System regulation target
   always @* begin
      if (!bat_above_sysmin) begin
         next_target = sysmin_mv + `CQT_SYS_BOOST_MV;
      end else if (terminated || !charge_allowed) begin
         next_target = battery_mv + `CQT_BAT_BOOST_MV;
      end else begin
         next_target = battery_mv;
      end
   end

   // Safety limit selection
   always @* begin
      if (!bat_above_low) begin
         limit = CYCLES_PER_HOUR[43:0] * `CQT_HOURS_SHORT;
      end else if (long_limit_select) begin
         limit = CYCLES_PER_HOUR[43:0] * `CQT_HOURS_LONG;
      end else begin
         limit = CYCLES_PER_HOUR[43:0] * `CQT_HOURS_MID;
      end
   end

   // Charge control and safety timer
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         en_sync <= 2'b11;
         en_last <= 1'b1;
         cfg_last <= 1'b1;
         zone <= `CQT_ZONE_NORMAL;
         in_window <= 1'b0;
         charging <= 1'b0;
         timer <= 44'h0;
         half_tick <= 1'b0;
         charge_fault_code <= 2'h0;
         expire_evt <= 1'b0;
         charge_current <= 8'h00;
         charge_voltage <= 13'h0;
         system_target <= 13'h0;
         system_regulation_flag <= 1'b0;
         input_current_limit_flag <= 1'b0;
         input_voltage_limit_flag <= 1'b0;
         host_irq_n <= 1'b1;
      end else begin
         en_sync <= {en_sync[0], charge_enable_n};
         en_last <= en_sync[1];
         cfg_last <= charge_config_bit;
         zone <= next_zone;
         in_window <= cold_ok & hot_ok;
         expire_evt <= 1'b0;
         half_tick <= ~half_tick;
         charge_current <= next_current;
         charge_voltage <= next_voltage;
         system_target <= next_target;
         host_irq_n <= irq_pin;
         system_regulation_flag <= ~bat_above_sysmin;
         input_current_limit_flag <= input_current_limit & charging;
         input_voltage_limit_flag <= input_voltage_limit & charging;
         if (toggle || recharge_req) begin
            timer <= 44'h0;
            charge_fault_code <= 2'h0;
            charging <= 1'b0;
         end else if (!charging) begin
            if (charge_allowed && !bat_full && !terminated &&
               charge_fault_code == 2'h0 && !other_fault &&
               (in_window || !temp_en)) begin
               charging <= 1'b1;
               timer <= 44'h0;
            end
         end else if (!charge_allowed || terminated) begin
            charging <= 1'b0;
         end else if (timer_en) begin
            if (timer >= limit) begin
               charging <= 1'b0;
               charge_fault_code <= `CQT_FAULT_TIMER;
               expire_evt <= 1'b1;
            end else if (other_fault ||
               (temp_en && !in_window)) begin
               timer <= timer;
            end else if (half_rate_enable && (input_current_limit ||
               input_voltage_limit || thermal_limit ||
               (temp_en && zone == `CQT_ZONE_COOL))) begin
               timer <= timer + {43'h0, half_tick};
            end else begin
               timer <= timer + 44'h1;
            end
         end
      end
   end

   // Boost temperature supervision
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         boost_active <= 1'b0;
         thermistor_fault <= `CQT_NTC_NORMAL;
         input_source_status <= 3'h0;
      end else if (!boost_req) begin
         boost_active <= 1'b0;
         thermistor_fault <= `CQT_NTC_NORMAL;
         input_source_status <= 3'h0;
      end else if (!boost_ok) begin
         boost_active <= 1'b0;
         input_source_status <= 3'h0;
         thermistor_fault <= cmp_clean[10] ? `CQT_NTC_BHOT :
            `CQT_NTC_BCOLD;
      end else begin
         boost_active <= 1'b1;
         thermistor_fault <= `CQT_NTC_NORMAL;
         input_source_status <= 3'h7;
      end
   end

   // AXI4-Lite slave: address and data held until both are present
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         ctrl <= `CQT_CTRL_RESET;
         chg <= `CQT_CHG_RESET;
      end else begin
         if (aw_take) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_hold && w_hold && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            if (aw_addr == `CQT_ADDR_CTRL && w_strb == 4'hF) begin
               ctrl <= w_data;
            end else if (aw_addr == `CQT_ADDR_CHARGE &&
               w_strb == 4'hF) begin
               chg <= w_data;
            end else begin
               s_axi_bresp <= 2'h2;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @* begin
      case (s_axi_araddr)
         `CQT_ADDR_CTRL: rd_word = ctrl;
         `CQT_ADDR_CHARGE: rd_word = chg;
         `CQT_ADDR_STATUS: rd_word = {22'h0, zone, input_source_status,
            system_regulation_flag, input_voltage_limit_flag,
            input_current_limit_flag, charging};
         `CQT_ADDR_FAULT: rd_word = {27'h0, thermistor_fault,
            charge_fault_code};
         `CQT_ADDR_TARGET: rd_word = {19'h0, system_target};
         default: rd_word = 32'h0;
      endcase
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= (s_axi_araddr > `CQT_ADDR_TARGET ||
            s_axi_araddr[1:0] != 2'b00) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // cqt_top

/* File: core/cqt_map.vh */
`ifndef CQT_MAP_VH
`define CQT_MAP_VH
// Register byte addresses
`define CQT_ADDR_CTRL 8'h00
`define CQT_ADDR_CHARGE 8'h04
`define CQT_ADDR_STATUS 8'h08
`define CQT_ADDR_FAULT 8'h0C
`define CQT_ADDR_TARGET 8'h10
// Control register fields
`define CQT_CTRL_TEMP_EN 0
`define CQT_CTRL_TIMER_EN 1
`define CQT_CTRL_LONG_SEL 2
`define CQT_CTRL_HALF_EN 3
`define CQT_CTRL_CHG_CFG 4
`define CQT_CTRL_WARM_V 5
`define CQT_CTRL_WARM_I_LO 6
`define CQT_CTRL_COOL_I 8
`define CQT_CTRL_COOL_EN 9
`define CQT_CTRL_COOL_V 10
`define CQT_CTRL_COOL_T_LO 11
`define CQT_CTRL_WARM_T_LO 13
`define CQT_CTRL_SYSMIN_LO 15
`define CQT_CTRL_BOOST 18
`define CQT_CTRL_RESET 32'h0002_B1DF
// Charge register: current [7:0], voltage in mV [28:16]
`define CQT_CHG_RESET 32'h1070_0080
`define CQT_WARM_MV 13'd4100
`define CQT_SYSMIN_BASE_MV 13'd3000
`define CQT_SYSMIN_STEP_MV 13'd100
`define CQT_SYS_BOOST_MV 13'd180
`define CQT_BAT_BOOST_MV 13'd50
// Zone codes
`define CQT_ZONE_COLD 3'h0
`define CQT_ZONE_COOL 3'h1
`define CQT_ZONE_NORMAL 3'h2
`define CQT_ZONE_WARM 3'h3
`define CQT_ZONE_HOT 3'h4
// Fault codes
`define CQT_FAULT_TIMER 2'h3
`define CQT_NTC_NORMAL 3'h0
`define CQT_NTC_BCOLD 3'h5
`define CQT_NTC_BHOT 3'h6
// Timing
`define CQT_CLK_MHZ 100
`define CQT_IRQ_US 256
`define CQT_IRQ_CYCLES (`CQT_IRQ_US * `CQT_CLK_MHZ)
`define CQT_DEBOUNCE_CYCLES 8
`define CQT_HOURS_SHORT 2
`define CQT_HOURS_MID 7
`define CQT_HOURS_LONG 16
`define CQT_CYCLES_PER_HOUR 64'd360000000000
`endif

/* File: core/cqt_debounce.v */
`timescale 1ns/100ps
`include "cqt_map.vh"
module cqt_debounce #(
   parameter WIDTH = 8,
   parameter COUNT = `CQT_DEBOUNCE_CYCLES
) (
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Raw and clean levels
   input wire [WIDTH-1:0] raw,
   output reg [WIDTH-1:0] clean
);
   reg [WIDTH-1:0] sync_a;
   reg [WIDTH-1:0] sync_b;
   reg [WIDTH-1:0] last;
   reg [7:0] stable;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync_a <= {WIDTH{1'b0}};
         sync_b <= {WIDTH{1'b0}};
         last <= {WIDTH{1'b0}};
         stable <= 8'h00;
         clean <= {WIDTH{1'b0}};
      end else begin
         sync_a <= raw;
         sync_b <= sync_a;
         last <= sync_b;
         // Accept a new pattern only after it stays unchanged
         if (sync_b != last) begin
            stable <= 8'h00;
         end else if (stable < COUNT[7:0]) begin
            stable <= stable + 8'h01;
         end else begin
            clean <= last;
         end
      end
   end
endmodule // cqt_debounce

/* File: core/cqt_irq_pulse.v */
`timescale 1ns/100ps
`include "cqt_map.vh"
module cqt_irq_pulse #(
   parameter CYCLES = `CQT_IRQ_CYCLES
) (
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Event in, pin out
   input wire trigger,
   output reg irq_n
);
   reg [15:0] count;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         count <= 16'h0000;
         irq_n <= 1'b1;
      end else if (count != 16'h0000) begin
         count <= count - 16'h0001;
         irq_n <= (count == 16'h0001);
      end else if (trigger) begin
         count <= CYCLES[15:0];
         irq_n <= 1'b0;
      end
   end
endmodule // cqt_irq_pulse

/* File: tb/cqt_afe_model.sv */
`timescale 1ns/100ps
// Thermistor front end: turns a sense voltage into comparator levels
module cqt_afe_model (
   // Sense level in mV
   input wire [12:0] sense_mv,
   // Comparator levels
   output logic [3:0] cool_cmp,
   output logic [3:0] warm_cmp,
   output logic cold_cmp,
   output logic hot_cmp,
   output logic boost_cold_cmp,
   output logic boost_hot_cmp
);
   // Colder means higher voltage: cold 800 > cool > warm > hot 300
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         cool_cmp[n] = sense_mv > (13'd720 - 13'(10 * n));
         warm_cmp[n] = sense_mv > (13'd430 - 13'(10 * n));
      end
      cold_cmp = sense_mv < 13'd800;
      hot_cmp = sense_mv > 13'd300;
      boost_cold_cmp = sense_mv < 13'd850;
      boost_hot_cmp = sense_mv > 13'd250;
   end
endmodule // cqt_afe_model

/* File: tb/cqt_checker.sv */
`timescale 1ns/100ps
module cqt_checker #(
   parameter IRQ_CYCLES = 25600
) (
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Charger
   input wire boost_cold_cmp,
   input wire boost_hot_cmp,
   input wire boost_active,
   input wire charging,
   input wire host_irq_n,
   input wire terminated,
   input wire bat_above_sysmin,
   input wire [12:0] battery_mv,
   input wire [12:0] system_target
);
   logic [31:0] low_cnt;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) low_cnt <= 32'h0;
      else if (host_irq_n) low_cnt <= 32'h0;
      else low_cnt <= low_cnt + 32'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence boost_out;
      !(boost_cold_cmp && boost_hot_cmp);
   endsequence
   sequence out_long;
      boost_out [*8] ##1 boost_out [*8];
   endsequence
   a_boost_suspend: assert property (out_long |=> !boost_active)
      else $error("boost stays on outside its window");
   a_irq_width: assert property ($rose(host_irq_n) |-> low_cnt == IRQ_CYCLES)
      else $error("interrupt pulse width wrong");
   a_irq_stop: assert property ($fell(host_irq_n) |-> !charging)
      else $error("charging continues at timer expiry");
   a_sys_follow: assert property ((terminated && bat_above_sysmin
      && $stable(battery_mv)) [*3] |-> system_target == battery_mv + 13'd50)
      else $error("system target not battery plus 50");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_write_refuse: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
endmodule // cqt_checker
bind cqt_top cqt_checker #(.IRQ_CYCLES(IRQ_CYCLES)) u_chk (.*);

/* File: tb/test_charge_qualification_timer.sv */
`timescale 1ns/100ps
`include "cqt_map.vh"
module test_charge_qualification_timer;
   localparam logic [31:0] CB = 32'h0002_B01D;
   logic clk_sys = 0, nrst = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [3:0] cool_cmp, warm_cmp;
   logic cold_cmp, hot_cmp, bcold, bhot;
   logic ce_n = 0, low = 0, above_min = 0, term = 0, icl = 0, ivl = 0;
   logic thm = 0, flt = 0;
   logic [12:0] sense = 13'd550, bat_mv = 13'd3200;
   logic charging, boost, irq_n;
   logic [7:0] cur;
   logic [12:0] volt, target;
   logic [31:0] d;
   int num_errors = 0, checks_done = 0, cyc = 0, n;
   cqt_afe_model afe (.sense_mv(sense), .cool_cmp(cool_cmp),
      .warm_cmp(warm_cmp), .cold_cmp(cold_cmp), .hot_cmp(hot_cmp),
      .boost_cold_cmp(bcold), .boost_hot_cmp(bhot));
   cqt_top #(.CYCLES_PER_HOUR(64'd100), .IRQ_CYCLES(50), .DEBOUNCE(8)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cool_cmp(cool_cmp),
      .warm_cmp(warm_cmp), .cold_cmp(cold_cmp), .hot_cmp(hot_cmp),
      .boost_cold_cmp(bcold), .boost_hot_cmp(bhot), .charge_enable_n(ce_n),
      .bat_above_low(low), .bat_above_sysmin(above_min), .bat_full(1'b0),
      .recharge_req(1'b0), .terminated(term), .input_current_limit(icl),
      .input_voltage_limit(ivl), .thermal_limit(thm), .other_fault(flt),
      .battery_mv(bat_mv), .charging(charging), .boost_active(boost),
      .charge_current(cur), .charge_voltage(volt), .system_target(target),
      .host_irq_n(irq_n));
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   task complete_run();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task wt(int k);
      repeat (k) @(posedge clk_sys);
   endtask
   task axw(logic [7:0] a, logic [31:0] v);
      @(posedge clk_sys);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
   endtask
   task axr(logic [7:0] a);
      @(posedge clk_sys);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      d = rdata; r = rresp;
      rready <= 0;
   endtask
   task t_regs();
      axr(`CQT_ADDR_CTRL); chk("ctrl reset", `CQT_CTRL_RESET, d);
      axr(`CQT_ADDR_CHARGE); chk("charge reset", `CQT_CHG_RESET, d);
      axr(8'h14); chk("unmapped resp", 2'h2, r); chk("unmapped data", 0, d);
      axw(8'h14, 32'h0000_FFFF); chk("unmapped write", 2'h2, r);
   endtask
   task t_sys();
      chk("target below min", 13'd3680, target);
      axr(`CQT_ADDR_STATUS); chk("sysreg flag", 1, d[3]);
      above_min <= 1; bat_mv <= 13'd3900; icl <= 1; wt(10);
      axr(`CQT_ADDR_STATUS); chk("icl flag", 3'h1, d[3:1]);
      icl <= 0; ivl <= 1; wt(10);
      axr(`CQT_ADDR_STATUS); chk("ivl flag", 3'h2, d[3:1]);
      ivl <= 0; term <= 1; wt(10);
      chk("target after term", 13'd3950, target);
      term <= 0; above_min <= 0;
   endtask
   task zone(logic [31:0] c, logic [12:0] s, logic [7:0] i, logic [12:0] v);
      axw(`CQT_ADDR_CTRL, c);
      sense <= s; wt(30);
      chk("charge current", i, cur);
      if (v != 0) chk("charge voltage", v, volt);
   endtask
   task t_start();
      sense <= 13'd900; wt(20); ce_n <= 1; wt(10); ce_n <= 0; wt(40);
      chk("start outside window", 0, charging);
      sense <= 13'd550; wt(40); chk("start inside window", 1, charging);
   endtask
   task t_boost();
      ce_n <= 1; axw(`CQT_ADDR_CTRL, CB | 32'h0004_0000); wt(30);
      chk("boost on", 1, boost);
      sense <= 13'd900; wt(30); chk("boost cold", 0, boost);
      axr(`CQT_ADDR_STATUS); chk("source status", 0, d[6:4]);
      axr(`CQT_ADDR_FAULT); chk("fault cold", `CQT_NTC_BCOLD, d[4:2]);
      sense <= 13'd200; wt(30);
      axr(`CQT_ADDR_FAULT); chk("fault hot", `CQT_NTC_BHOT, d[4:2]);
      sense <= 13'd550; wt(30); chk("boost resumed", 1, boost);
      axr(`CQT_ADDR_FAULT); chk("fault cleared", 0, d[4:2]);
      axw(`CQT_ADDR_CTRL, CB); ce_n <= 0;
   endtask
   task tmr(logic [31:0] c, logic [1:0] ic, logic lo, int e, int p = 0);
      icl <= ic[0]; thm <= ic[1]; low <= lo; axw(`CQT_ADDR_CTRL, c);
      ce_n <= 1; wt(10); ce_n <= 0;
      n = 0;
      while (charging !== 1'b1 && n < 100) begin wt(1); n++; end
      if (p > 0) begin flt <= 1; wt(p); flt <= 0; end
      n = 0;
      while (irq_n === 1'b1 && n < e + 250) begin wt(1); n++; end
      if (e == 0) begin
         chk("no expiry", 1, irq_n);
         return;
      end
      chk("expiry time", 1, n >= e - 8 && n <= e + 12);
      axr(`CQT_ADDR_FAULT); chk("timer fault", `CQT_FAULT_TIMER, d[1:0]);
      chk("charging stopped", 0, charging);
      wt(60);
   endtask
   initial begin
      wt(20);
      nrst <= 1;
      t_regs();
      t_sys();
      zone(CB, 550, 128, 4208);
      zone(CB, 900, 0, 0);
      zone(CB, 200, 0, 0);
      zone(CB | 32'h80, 350, 64, 4100);
      zone(CB | 32'h20, 350, 0, 4208);
      zone(CB | 32'h40, 350, 25, 4100);
      zone(CB | 32'h200, 750, 64, 4208);
      zone(CB | 32'h700, 750, 25, 4100);
      zone(CB, 750, 0, 0);
      zone(CB & ~32'h1, 200, 128, 4208);
      zone(32'h0002_A21D, 705, 128, 4208);
      zone(32'h0002_BA1D, 705, 64, 0);
      zone(CB, 550, 128, 4208);
      t_start();
      t_boost();
      tmr(CB | 32'h2, 0, 0, 202);
      tmr(CB | 32'h2, 1, 0, 402);
      tmr(CB | 32'h2, 2, 0, 402);
      tmr(CB | 32'h2, 0, 0, 202, 100);
      tmr((CB | 32'h2) & ~32'h8, 1, 0, 202);
      tmr(CB | 32'h2, 0, 1, 1602);
      tmr((CB | 32'h2) & ~32'h4, 0, 1, 702);
      tmr(CB, 0, 0, 0);
      complete_run();
   end
endmodule // test_charge_qualification_timer
